// file: hw/nvm_program_erase_control.sv
// nvm program/erase/read sequencer behind an axi4-lite register slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module nvm_program_erase_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [15:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [15:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic write_protect,
   input wire logic abort_req,
   output nvm_pkg::flash_cmd_t fl_cmd,
   output logic fl_valid,
   input wire logic fl_done,
   input wire logic [13:0] fl_rdata
);
   // ============================================================
   // address decode shared by both channels
   function automatic nvm_pkg::reg_sel_t decode(input logic [15:0] a);
      nvm_pkg::reg_sel_t s;
      s = nvm_pkg::SEL_NONE;
      if (a == nvm_pkg::BA_ADDR) begin
         s = nvm_pkg::SEL_ADDR;
      end else if (a == nvm_pkg::BA_DATA) begin
         s = nvm_pkg::SEL_DATA;
      end else if (a == nvm_pkg::BA_CTRL) begin
         s = nvm_pkg::SEL_CTRL;
      end else if (a == nvm_pkg::BA_KEY) begin
         s = nvm_pkg::SEL_KEY;
      end
      return s;
   endfunction

   // ============================================================
   // state
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic aw_got_ff, w_got_ff;
   logic [15:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [14:0] addr_ff;
   logic [13:0] data_ff;
   logic region_ff, latch_ff, erase_ff, permit_ff, err_ff, wr_ff, rd_ff;
   nvm_pkg::unlock_state_t ul_ff, nxt_ul;
   nvm_pkg::op_state_t st_ff, nxt_st;
   nvm_pkg::flash_cmd_t fl_cmd_ff, nxt_cmd;
   logic fl_valid_ff, nxt_valid, nxt_wr, nxt_rd, nxt_err;
   logic [4:0] word_idx_ff, lat_idx;
   logic lat_load, lat_clear, rd_capture, erase_done;
   logic [13:0] lat_rd;

   // ============================================================
   // bus handshake terms
   logic aw_take, w_take, ar_take, do_write;
   nvm_pkg::reg_sel_t wsel, rsel;
   assign aw_take = awvalid & awready_ff;
   assign w_take = wvalid & wready_ff;
   assign ar_take = arvalid & arready_ff;
   assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign wsel = decode(aw_addr_ff);
   assign rsel = decode(araddr);

   // ============================================================
   // register write strobes and unlock decode
   logic busy, ctrl_wr, key_wr, key_first, key_second, ul_broken;
   logic go, go_latch, go_mem, go_read, prot_hit, abort_err, err_clr;
   logic [7:0] wbyte;
   logic step_done, row_end;
   assign busy = (st_ff != nvm_pkg::ST_IDLE);
   assign wbyte = w_data_ff[7:0];
   assign ctrl_wr = do_write & (wsel == nvm_pkg::SEL_CTRL) & w_strb_ff[0];
   assign key_wr = do_write & (wsel == nvm_pkg::SEL_KEY) & w_strb_ff[0];
   // key value only feeds the pattern match
   assign key_first = key_wr & (wbyte == nvm_pkg::KEY_FIRST);
   assign key_second = key_wr & (wbyte == nvm_pkg::KEY_SECOND)
                       & (ul_ff == nvm_pkg::UL_GOT_FIRST);
   // any write but the expected next one breaks an open sequence
   assign ul_broken = do_write & (ul_ff != nvm_pkg::UL_IDLE) & ~key_second
                      & ~(ctrl_wr & (ul_ff == nvm_pkg::UL_ARMED));
   assign go = ctrl_wr & wbyte[nvm_pkg::BIT_WR] & (ul_ff == nvm_pkg::UL_ARMED)
               & permit_ff & ~busy;
   assign go_latch = go & wbyte[nvm_pkg::BIT_LATCH] & ~wbyte[nvm_pkg::BIT_ERASE];
   assign prot_hit = go & ~go_latch & write_protect & ~wbyte[nvm_pkg::BIT_REGION];
   assign go_mem = go & ~go_latch & ~prot_hit;
   assign go_read = ctrl_wr & wbyte[nvm_pkg::BIT_RD] & ~busy & ~go;
   assign abort_err = abort_req & ((st_ff == nvm_pkg::ST_ERASE) | (st_ff == nvm_pkg::ST_PROG));
   assign err_clr = ctrl_wr & ~wbyte[nvm_pkg::BIT_ERR];
   assign step_done = fl_valid_ff & fl_done;
   assign row_end = (st_ff == nvm_pkg::ST_PROG) & step_done
                    & (word_idx_ff == nvm_pkg::ROW_LAST);
   // set wins over clear; software one also sets
   assign nxt_err = prot_hit | ul_broken | abort_err | (ctrl_wr & wbyte[nvm_pkg::BIT_ERR])
                    | (err_ff & ~err_clr);
   assign nxt_ul = key_first ? nvm_pkg::UL_GOT_FIRST :
                   key_second ? nvm_pkg::UL_ARMED :
                   do_write ? nvm_pkg::UL_IDLE : ul_ff;
   assign lat_idx = (st_ff == nvm_pkg::ST_IDLE) ? 5'h00 :
                    (st_ff == nvm_pkg::ST_PROG && step_done) ? 5'(word_idx_ff + 5'h01) :
                    word_idx_ff;

   // ============================================================
   // operation sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_valid = fl_valid_ff;
      nxt_cmd = fl_cmd_ff;
      lat_load = 1'b0;
      lat_clear = 1'b0;
      rd_capture = 1'b0;
      erase_done = 1'b0;
      case (st_ff)
         nvm_pkg::ST_IDLE: begin
            if (go_latch) begin
               nxt_st = nvm_pkg::ST_LATCH;
               nxt_wr = 1'b1;
            end else if (go_mem) begin
               nxt_wr = 1'b1;
               nxt_valid = 1'b1;
               nxt_cmd.region = wbyte[nvm_pkg::BIT_REGION];
               nxt_cmd.addr = {addr_ff[14:5], 5'h00};
               if (wbyte[nvm_pkg::BIT_ERASE]) begin
                  nxt_st = nvm_pkg::ST_ERASE;
                  nxt_cmd.op = nvm_pkg::OP_ERASE;
                  nxt_cmd.wdata = nvm_pkg::LATCH_RESET;
               end else begin
                  nxt_st = nvm_pkg::ST_PROG;
                  nxt_cmd.op = nvm_pkg::OP_PROG;
                  nxt_cmd.wdata = lat_rd;
               end
            end else if (go_read) begin
               nxt_st = nvm_pkg::ST_READ;
               nxt_rd = 1'b1;
               nxt_valid = 1'b1;
               nxt_cmd.op = nvm_pkg::OP_READ;
               nxt_cmd.region = wbyte[nvm_pkg::BIT_REGION];
               nxt_cmd.addr = addr_ff;
            end
         end
         nvm_pkg::ST_LATCH: begin
            lat_load = 1'b1;
            nxt_wr = 1'b0;
            nxt_st = nvm_pkg::ST_IDLE;
         end
         nvm_pkg::ST_ERASE: begin
            if (step_done) begin
               nxt_wr = 1'b0;
               nxt_valid = 1'b0;
               erase_done = 1'b1;
               nxt_st = nvm_pkg::ST_IDLE;
            end
         end
         nvm_pkg::ST_PROG: begin
            if (row_end) begin
               nxt_wr = 1'b0;
               nxt_valid = 1'b0;
               lat_clear = 1'b1;
               nxt_st = nvm_pkg::ST_IDLE;
            end else if (step_done) begin
               nxt_cmd.addr = {addr_ff[14:5], lat_idx};
               nxt_cmd.wdata = lat_rd;
            end
         end
         nvm_pkg::ST_READ: begin
            if (step_done) begin
               rd_capture = 1'b1;
               nxt_rd = 1'b0;
               nxt_valid = 1'b0;
               nxt_st = nvm_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_st = nvm_pkg::ST_IDLE;
         end
      endcase
      // an abort ends any operation at once
      if (abort_req && busy) begin
         nxt_st = nvm_pkg::ST_IDLE;
         nxt_wr = 1'b0;
         nxt_rd = 1'b0;
         nxt_valid = 1'b0;
      end
   end

   // sequencer registers; a zero written to the start bit is never looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= nvm_pkg::ST_IDLE;
         wr_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_WR];
         rd_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_RD];
         fl_valid_ff <= 1'b0;
         fl_cmd_ff <= '0;
         word_idx_ff <= 5'h00;
         ul_ff <= nvm_pkg::UL_IDLE;
      end else if (ce) begin
         st_ff <= nxt_st;
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         fl_valid_ff <= nxt_valid;
         fl_cmd_ff <= nxt_cmd;
         word_idx_ff <= lat_idx;
         ul_ff <= nxt_ul;
      end
   end

   // ============================================================
   // software registers; fields except the error flag frozen while an operation runs, erase bit cleared when the erase completes, not on an abort
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         region_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_REGION];
         latch_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_LATCH];
         erase_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_ERASE];
         permit_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_PERMIT];
         err_ff <= nvm_pkg::CTRL_RESET[nvm_pkg::BIT_ERR];
      end else if (ce) begin
         err_ff <= nxt_err;
         if (ctrl_wr && !busy) begin
            region_ff <= wbyte[nvm_pkg::BIT_REGION];
            latch_ff <= wbyte[nvm_pkg::BIT_LATCH];
            erase_ff <= wbyte[nvm_pkg::BIT_ERASE];
            permit_ff <= wbyte[nvm_pkg::BIT_PERMIT];
         end else if (erase_done) begin
            erase_ff <= 1'b0;
         end
      end
   end

   // address and data words, byte lanes 0 and 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_ff <= nvm_pkg::ADDR_RESET;
         data_ff <= nvm_pkg::DATA_RESET;
      end else if (ce) begin
         if (do_write && !busy && wsel == nvm_pkg::SEL_ADDR) begin
            if (w_strb_ff[0]) addr_ff[7:0] <= w_data_ff[7:0];
            if (w_strb_ff[1]) addr_ff[14:8] <= w_data_ff[14:8];
         end
         if (rd_capture) begin
            data_ff <= fl_rdata;
         end else if (do_write && !busy && wsel == nvm_pkg::SEL_DATA) begin
            if (w_strb_ff[0]) data_ff[7:0] <= w_data_ff[7:0];
            if (w_strb_ff[1]) data_ff[13:8] <= w_data_ff[13:8];
         end
      end
   end

   // ============================================================
   // write latches
   nvm_row_latches u_latches (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .load(lat_load),
      .clear_all(lat_clear),
      .load_idx(addr_ff[4:0]),
      .load_data(data_ff),
      .rd_idx(lat_idx),
      .rd_data(lat_rd)
   );

   // ============================================================
   // axi4-lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         aw_addr_ff <= 16'h0000;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         bresp_ff <= nvm_pkg::RESP_OKAY;
      end else if (ce) begin
         awready_ff <= ~aw_take & ~aw_got_ff & ~bvalid_ff & ~do_write;
         wready_ff <= ~w_take & ~w_got_ff & ~bvalid_ff & ~do_write;
         if (aw_take) begin
            aw_addr_ff <= awaddr;
         end
         if (w_take) begin
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
         end
         aw_got_ff <= do_write ? 1'b0 : (aw_got_ff | aw_take);
         w_got_ff <= do_write ? 1'b0 : (w_got_ff | w_take);
         if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wsel == nvm_pkg::SEL_NONE) ? nvm_pkg::RESP_SLVERR : nvm_pkg::RESP_OKAY;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ============================================================
   // axi4-lite read channel; key register reads as zero
   logic [7:0] ctrl_byte;
   logic [31:0] rd_word;
   always_comb begin
      ctrl_byte = 8'h00;
      ctrl_byte[nvm_pkg::BIT_RD] = rd_ff;
      ctrl_byte[nvm_pkg::BIT_WR] = wr_ff;
      ctrl_byte[nvm_pkg::BIT_PERMIT] = permit_ff;
      ctrl_byte[nvm_pkg::BIT_ERR] = err_ff;
      ctrl_byte[nvm_pkg::BIT_ERASE] = erase_ff;
      ctrl_byte[nvm_pkg::BIT_LATCH] = latch_ff;
      ctrl_byte[nvm_pkg::BIT_REGION] = region_ff;
   end
   assign rd_word = (rsel == nvm_pkg::SEL_ADDR) ? {17'h00000, addr_ff} :
                    (rsel == nvm_pkg::SEL_DATA) ? {18'h00000, data_ff} :
                    (rsel == nvm_pkg::SEL_CTRL) ? {24'h000000, ctrl_byte} :
                    32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= nvm_pkg::RESP_OKAY;
      end else if (ce) begin
         arready_ff <= ~ar_take & ~rvalid_ff;
         if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= (rsel == nvm_pkg::SEL_NONE) ? nvm_pkg::RESP_SLVERR : nvm_pkg::RESP_OKAY;
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // output pins straight from flops
   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign fl_cmd = fl_cmd_ff;
   assign fl_valid = fl_valid_ff;

   // ============================================================
   // checks
   sequence s_row_end;
      row_end && !abort_req;
   endsequence
   sequence s_back_idle;
      st_ff == nvm_pkg::ST_IDLE && !wr_ff && !fl_valid_ff;
   endsequence

   erase_row_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      st_ff == nvm_pkg::ST_ERASE |-> fl_valid_ff && wr_ff
         && fl_cmd_ff.op == nvm_pkg::OP_ERASE && fl_cmd_ff.addr[4:0] == 5'h00)
      else $error("erase not issued on row base");
   prog_no_erase_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      st_ff == nvm_pkg::ST_PROG |-> fl_cmd_ff.op == nvm_pkg::OP_PROG)
      else $error("program issued a non-program command");
   err_sticky_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      err_ff && !err_clr |=> err_ff)
      else $error("error flag dropped without software");
   permit_gate_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      !permit_ff && !wr_ff |=> !wr_ff)
      else $error("start bit set while permit low");
   start_unlock_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      $rose(wr_ff) |-> $past(ul_ff) == nvm_pkg::UL_ARMED)
      else $error("start accepted without unlock");
   start_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      wr_ff && ctrl_wr && !wbyte[nvm_pkg::BIT_WR] && st_ff != nvm_pkg::ST_LATCH
         && !step_done && !abort_req |=> wr_ff)
      else $error("zero write stopped operation");
   read_done_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      st_ff == nvm_pkg::ST_READ && step_done && !abort_req
         |=> !rd_ff && data_ff == $past(fl_rdata))
      else $error("read result not captured");
   latch_load_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      go_latch |=> st_ff == nvm_pkg::ST_LATCH ##1 s_back_idle)
      else $error("latch load did not finish in two cycles");
   row_reset_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      s_row_end |=> s_back_idle and lat_rd == nvm_pkg::LATCH_RESET)
      else $error("latches not reset after row write");
   prot_err_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      prot_hit |=> err_ff && !wr_ff && st_ff == nvm_pkg::ST_IDLE)
      else $error("protected start not refused with error");
endmodule

// file: include/nvm_pkg.sv
// nvm sequencer package: register map, fields, reset values, carriers
// Function
// - erase sets addressed 32-word row to ones
// - erase clear means write without erase
// - error flag shows one after failed write
// - error flag cleared only by software
// - software may set error flag deliberately
// - error flag meaningless while operation runs
// - permit bit low blocks program and erase
// - start bit launches operation at address
// - start accepted only right after unlock
// - operations self-timed, start bit clears itself
// - writing zero to start bit does nothing
// - read bit reads flash, clears when done
// - unlock key register eight bits, reset zero
// - latch-only start loads data into latch
// - row write, then latches reset 0x3fff
// - protection, abort of erase or program, broken unlock set error
// - region bit selects information or program flash
package nvm_pkg;
   // ============================================================
   // register indices and byte addresses
   localparam logic [15:0] IDX_ADDR = 16'h1c8c;
   localparam logic [15:0] IDX_DATA = 16'h1c8e;
   localparam logic [15:0] IDX_CTRL = 16'h1c90;
   localparam logic [15:0] IDX_KEY = 16'h1c91;
   localparam logic [15:0] BA_ADDR = {IDX_ADDR[13:0], 2'b00};
   localparam logic [15:0] BA_DATA = {IDX_DATA[13:0], 2'b00};
   localparam logic [15:0] BA_CTRL = {IDX_CTRL[13:0], 2'b00};
   localparam logic [15:0] BA_KEY = {IDX_KEY[13:0], 2'b00};
   // ============================================================
   // control field positions
   localparam int BIT_RD = 0;
   localparam int BIT_WR = 1;
   localparam int BIT_PERMIT = 2;
   localparam int BIT_ERR = 3;
   localparam int BIT_ERASE = 4;
   localparam int BIT_LATCH = 5;
   localparam int BIT_REGION = 6;
   // ============================================================
   // reset values, key pattern, row geometry
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [14:0] ADDR_RESET = 15'h0000;
   localparam logic [13:0] DATA_RESET = 14'h0000;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam logic [13:0] LATCH_RESET = 14'h3fff;
   localparam int ROW_WORDS = 32;
   localparam logic [4:0] ROW_LAST = 5'h1f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ============================================================
   // types
   typedef enum logic [1:0] {OP_READ, OP_ERASE, OP_PROG} flash_op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_ERASE, ST_PROG, ST_READ} op_state_t;
   typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_ARMED} unlock_state_t;
   typedef enum logic [2:0] {SEL_NONE, SEL_ADDR, SEL_DATA, SEL_CTRL, SEL_KEY} reg_sel_t;
   typedef struct packed {
      flash_op_t op;
      logic region;
      logic [14:0] addr;
      logic [13:0] wdata;
   } flash_cmd_t;
endpackage

// file: hw/nvm_row_latches.sv
// row write latches: 32 words, single load, bulk reset, indexed read
`timescale 1ns/1ps
module nvm_row_latches (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic load,
   input wire logic clear_all,
   input wire logic [4:0] load_idx,
   input wire logic [13:0] load_data,
   input wire logic [4:0] rd_idx,
   output logic [13:0] rd_data
);
   logic [13:0] word_ff [0:nvm_pkg::ROW_WORDS-1];

   // ============================================================
   // one latch per word of the row
   genvar i;
   generate
      for (i = 0; i < nvm_pkg::ROW_WORDS; i++) begin : g_word
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               word_ff[i] <= nvm_pkg::LATCH_RESET;
            end else if (ce) begin
               if (clear_all) begin
                  word_ff[i] <= nvm_pkg::LATCH_RESET;
               end else if (load && load_idx == 5'(i)) begin
                  word_ff[i] <= load_data;
               end
            end
         end
      end
   endgenerate

   assign rd_data = word_ff[rd_idx];
endmodule

// file: verification/nvm_flash_model.sv
// behavioural flash array: answers each command after a fixed delay and logs it
`timescale 1ns/1ps
module nvm_flash_model #(
   parameter int DELAY = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire nvm_pkg::flash_cmd_t fl_cmd,
   input wire logic fl_valid,
   output logic fl_done,
   output logic [13:0] fl_rdata,
   output logic [7:0] n_erase,
   output logic [7:0] n_prog,
   output nvm_pkg::flash_cmd_t last_cmd
);
   logic [7:0] cnt_ff;
   // ============================================================
   // one done pulse per command; read data only valid with done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 8'h00;
         fl_done <= 1'b0;
         fl_rdata <= 14'h0000;
         n_erase <= 8'h00;
         n_prog <= 8'h00;
         last_cmd <= '0;
      end else begin
         fl_done <= 1'b0;
         fl_rdata <= ~fl_rdata; // no stale data outside done
         if (fl_valid && !fl_done) begin
            cnt_ff <= cnt_ff + 8'h01;
            if (cnt_ff == 8'(DELAY)) begin
               cnt_ff <= 8'h00;
               fl_done <= 1'b1;
               last_cmd <= fl_cmd;
               fl_rdata <= fl_cmd.addr[13:0] ^ 14'h2a5a;
               if (fl_cmd.op == nvm_pkg::OP_ERASE) n_erase <= n_erase + 8'h01;
               if (fl_cmd.op == nvm_pkg::OP_PROG) n_prog <= n_prog + 8'h01;
            end
         end else if (!fl_valid) begin
            cnt_ff <= 8'h00; // a withdrawn command leaves no stale count
         end
      end
   end
endmodule

// file: verification/tb.sv
// testbench: register sequences over axi4-lite against the flash model
`timescale 1ns/1ps
module tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, write_protect = 0, abort_req = 0, bvalid, rvalid;
   logic awready, wready, arready, fl_valid, fl_done;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, br;
   logic [13:0] fl_rdata;
   logic [7:0] n_erase, n_prog;
   nvm_pkg::flash_cmd_t fl_cmd, last_cmd;
   int num_errors = 0, total_checks = 0;
   always #5 aclk = ~aclk;
   nvm_program_erase_control DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .write_protect(write_protect), .abort_req(abort_req),
      .fl_cmd(fl_cmd), .fl_valid(fl_valid), .fl_done(fl_done), .fl_rdata(fl_rdata));
   nvm_flash_model flash (.aclk(aclk), .aresetn(aresetn), .fl_cmd(fl_cmd),
      .fl_valid(fl_valid), .fl_done(fl_done), .fl_rdata(fl_rdata), .n_erase(n_erase),
      .n_prog(n_prog), .last_cmd(last_cmd));
   // ============================================================
   // checking and closing
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ============================================================
   // bus master tasks: hold each channel until its ready
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [15:0] a, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a);
      logic [1:0] r;
      rdr(a, r);
   endtask
   task automatic unlock;
      wr(nvm_pkg::BA_KEY, 32'h55);
      wr(nvm_pkg::BA_KEY, 32'haa);
   endtask
   // poll the control word until the masked busy bits drop
   task automatic wait_idle(input logic [31:0] mask);
      int n;
      n = 0;
      do begin
         rdc(nvm_pkg::BA_CTRL);
         n++;
      end while ((rd & mask) != 0 && n < 200);
      if (n >= 200) begin
         num_errors++;
         finish_test;
      end
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      finish_test;
   end
   initial begin
      logic [1:0] r;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, write-only key, unmapped place
      rdc(nvm_pkg::BA_CTRL); chk("ctrl reset", rd, 32'h0);
      wr(nvm_pkg::BA_KEY, 32'h55);
      rdc(nvm_pkg::BA_KEY); chk("key read", rd, 32'h0);
      rdr(16'h0100, r); chk("unmapped resp", 32'(r), 32'(nvm_pkg::RESP_SLVERR));
      wr(16'h0100, 32'h0); // breaks the open sequence
      chk("unmapped bresp", 32'(br), 32'(nvm_pkg::RESP_SLVERR));
      wr(nvm_pkg::BA_CTRL, 32'h0); // clears any error from the open sequence
      $display("test reset done");
      // start without unlock is ignored
      wr(nvm_pkg::BA_CTRL, 32'h04);
      wr(nvm_pkg::BA_CTRL, 32'h06);
      rdc(nvm_pkg::BA_CTRL); chk("start no key", rd, 32'h04);
      // broken unlock sets error; software clears and sets it
      wr(nvm_pkg::BA_KEY, 32'h55);
      wr(nvm_pkg::BA_ADDR, 32'h0);
      rdc(nvm_pkg::BA_CTRL); chk("broken unlock", rd, 32'h0c);
      wr(nvm_pkg::BA_CTRL, 32'h04);
      rdc(nvm_pkg::BA_CTRL); chk("err clear", rd, 32'h04);
      wr(nvm_pkg::BA_CTRL, 32'h0c);
      rdc(nvm_pkg::BA_CTRL); chk("err set", rd, 32'h0c);
      wr(nvm_pkg::BA_CTRL, 32'h04);
      $display("test error flag done");
      // erase of the row, a zero write to start mid-run
      wr(nvm_pkg::BA_ADDR, 32'h45);
      wr(nvm_pkg::BA_CTRL, 32'h14);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h16);
      wr(nvm_pkg::BA_CTRL, 32'h14);
      wait_idle(32'h02);
      chk("erase count", 32'(n_erase), 32'h1);
      chk("erase addr", 32'(last_cmd.addr), 32'h40);
      chk("erase done ctrl", rd, 32'h04);
      $display("test erase done");
      // permit low blocks the start
      wr(nvm_pkg::BA_CTRL, 32'h10);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h12);
      rdc(nvm_pkg::BA_CTRL); chk("no permit", rd & 32'h2, 32'h0);
      repeat (30) @(posedge aclk);
      chk("no permit cmd", 32'(n_erase), 32'h1);
      // protected erase: error, no command
      write_protect <= 1'b1;
      wr(nvm_pkg::BA_CTRL, 32'h14);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h16);
      rdc(nvm_pkg::BA_CTRL); chk("protected", rd & 32'h0a, 32'h08);
      write_protect <= 1'b0;
      wr(nvm_pkg::BA_CTRL, 32'h04);
      $display("test blocking done");
      // row program without erase: 32 words, the last latch loaded first
      wr(nvm_pkg::BA_ADDR, 32'h5f);
      wr(nvm_pkg::BA_DATA, 32'h1234);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h26);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h06);
      wait_idle(32'h02);
      chk("prog count", 32'(n_prog), 32'd32);
      chk("prog no erase", 32'(n_erase), 32'h1);
      chk("prog last addr", 32'(last_cmd.addr), 32'h5f);
      chk("prog done ctrl", rd, 32'h04);
      chk("latch word", 32'(last_cmd.wdata), 32'h1234);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h06);
      wait_idle(32'h02);
      chk("latch reset", 32'(last_cmd.wdata), 32'h3fff);
      // read at the address register
      wr(nvm_pkg::BA_ADDR, 32'h123);
      wr(nvm_pkg::BA_CTRL, 32'h45);
      wait_idle(32'h01);
      chk("read ctrl", rd, 32'h44);
      chk("read region", 32'(last_cmd.region), 32'h1);
      rdc(nvm_pkg::BA_DATA); chk("read data", rd, 32'(14'h0123 ^ 14'h2a5a));
      $display("test program read done");
      // abort of a running erase sets the error flag
      wr(nvm_pkg::BA_CTRL, 32'h14);
      unlock;
      wr(nvm_pkg::BA_CTRL, 32'h16);
      abort_req <= 1'b1;
      @(posedge aclk);
      abort_req <= 1'b0;
      rdc(nvm_pkg::BA_CTRL);
      chk("abort ctrl", rd & 32'h0b, 32'h08);
      chk("abort valid", 32'(fl_valid), 32'h0);
      $display("test abort done");
      finish_test;
   end
endmodule
